// File: logic/trbg_regs.svh
// register addresses, field positions, reset values and clock ratios of the tone and buzzer block
`ifndef TRBG_REGS_SVH
`define TRBG_REGS_SVH

// command byte: register address in bits 7..4, read request in bit 2
`define TRBG_CMD_ADDR_HI     7
`define TRBG_CMD_ADDR_LO     4
`define TRBG_CMD_READ_BIT    2

`define TRBG_ADDR_CLOCK      4'h0
`define TRBG_ADDR_ROUTING    4'h4
`define TRBG_ADDR_RX_GAIN    4'h6
`define TRBG_ADDR_TONE_CTRL  4'h7
`define TRBG_ADDR_FREQ_FIRST 4'h8
`define TRBG_ADDR_FREQ_SEC   4'h9
`define TRBG_ADDR_RANGE      4'ha
`define TRBG_ADDR_BUZZER     4'hb

`define TRBG_RST_CLOCK       8'h00
`define TRBG_RST_ROUTING     8'h00
`define TRBG_RST_RX_GAIN     8'h00
`define TRBG_RST_TONE_CTRL   8'h00
`define TRBG_RST_FREQ        8'h00
`define TRBG_RST_RANGE       8'h00
`define TRBG_RST_BUZZER      8'h00

`define TRBG_CLK_SEL_HI      7
`define TRBG_CLK_SEL_LO      6
`define TRBG_ROUTE_RING_BIT  2
`define TRBG_SIDETONE_BIT    5
`define TRBG_GAIN_HI         3
`define TRBG_GAIN_LO         0
`define TRBG_ATT_HI          7
`define TRBG_ATT_LO          4
`define TRBG_FIRST_EN_BIT    3
`define TRBG_SECOND_EN_BIT   2
`define TRBG_WAVE_BIT        1
`define TRBG_TO_TX_BIT       0
`define TRBG_BZ_EN_BIT       7
`define TRBG_BZ_POL_BIT      6
`define TRBG_DUTY_HI         5
`define TRBG_DUTY_LO         0

// master clock divided down to 512 kHz: ratios for 512k, 1.536M, 2.048M, 2.56M
`define TRBG_DIV_512K        3'h1
`define TRBG_DIV_1536K       3'h3
`define TRBG_DIV_2048K       3'h4
`define TRBG_DIV_2560K       3'h5

// 17-bit phase at 512 kHz gives a 3.90625 Hz step per increment
`define TRBG_PHASE_W         17
// second tone scaled by 203/256, about -2 dB
`define TRBG_SECOND_GAIN     9'sh0cb
`define TRBG_SQUARE_AMP      9'sh07f

`endif

// File: logic/trbg_pkg.sv
// types shared by the tone and buzzer block
package trbg_pkg;

    typedef enum logic [1:0] {
        PORT_IDLE = 2'b00,
        PORT_CMD  = 2'b01,
        PORT_DATA = 2'b11,
        PORT_DONE = 2'b10
    } trbg_port_state_t;

    typedef enum logic [1:0] {
        RANGE_STD    = 2'b00,
        RANGE_HALVED = 2'b01,
        RANGE_DOUBLE = 2'b10,
        RANGE_BOTH   = 2'b11
    } trbg_range_t;

endpackage

// File: logic/trbg_sine_rom.sv
// quarter-wave sine table with registered output, amplitude 127
module trbg_sine_rom (
    input  wire logic              sys_clk,
    input  wire logic              reset,
    input  wire logic [5:0]        phase,
    output logic signed [8:0]      sine_q
);
    logic [3:0] idx;
    logic [7:0] mag;

    assign idx = phase[4] ? ~phase[3:0] : phase[3:0];

    always_comb begin
        unique case (idx)
            4'h0: mag = 8'h06;
            4'h1: mag = 8'h13;
            4'h2: mag = 8'h1f;
            4'h3: mag = 8'h2b;
            4'h4: mag = 8'h36;
            4'h5: mag = 8'h41;
            4'h6: mag = 8'h4c;
            4'h7: mag = 8'h55;
            4'h8: mag = 8'h5e;
            4'h9: mag = 8'h66;
            4'ha: mag = 8'h6d;
            4'hb: mag = 8'h73;
            4'hc: mag = 8'h78;
            4'hd: mag = 8'h7b;
            4'he: mag = 8'h7e;
            4'hf: mag = 8'h7f;
        endcase
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            sine_q <= 9'sh000;
        end else if (phase[5]) begin
            sine_q <= -$signed({1'b0, mag});
        end else begin
            sine_q <= $signed({1'b0, mag});
        end
    end
endmodule

// File: logic/trbg_tone_gen.sv
// tone, ring and buzzer generator with its two-byte serial control port
// How it works
// - extra receive gain code is the low nibble of the receive gain register
// - upper nibble of tone control drives the ring attenuator code
// - tone control bits 3 and 2 enable first and second tone sources
// - a single enabled source runs at its own frequency register
// - both sources enabled: generator output is their sum
// - second source is scaled about 2 dB below the first
// - tone control bit 1 picks sine or square waveform
// - tone control bit 0 puts generator output on the transmit path
// - frequency is register value over 0.128, 0.256 or 0.064 Hz
// - range register bits 1 and 0 choose standard, halved or doubled
// - buzzer control bit 7 sends first-tone PWM to the buzzer pin
// - buzzer duty is the 6-bit field times 0.78125 percent
// - both sources enabled: buzzer PWM gated by second-tone square wave
// - buzzer control bit 6 picks whether duty counts high or low time
// - buzzer disabled or powered down: pin rests at the polarity bit
// - registers accessed by command byte then data byte
// - routing register bit 2 steers ring to extra or earpiece amplifier
// - sidetone enable bit, forced off while transmit path is disabled
`include "trbg_regs.svh"

module trbg_tone_gen (
    input  wire logic              sys_clk,
    input  wire logic              reset,
    input  wire logic              cs_n,
    input  wire logic              cclk,
    input  wire logic              ci,
    output logic                   co_out,
    output logic                   co_oe_n,
    input  wire logic              mclk,
    input  wire logic              power_down,
    input  wire logic              tx_path_enable,
    input  wire logic signed [9:0] tx_amp_sample,
    output logic signed [9:0]      tx_path_sample,
    output logic signed [9:0]      tone_sample,
    output logic [3:0]             ring_atten_code,
    output logic [3:0]             extra_gain_code,
    output logic                   ring_route_select,
    output logic                   sidetone_active,
    output logic                   buzzer_output
);
    localparam int PW = `TRBG_PHASE_W;

    // input synchronisers: order {power_down, tx_path_enable, mclk, ci, cclk, cs_n}
    logic [5:0] meta_q;
    logic [5:0] sync_q;
    logic       cclk_d_q;
    logic       mclk_d_q;
    logic       cs_n_s;
    logic       cclk_rise;
    logic       cclk_fall;
    logic       mclk_rise;
    logic       ci_s;
    logic       pd_s;
    logic       tx_en_s;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            meta_q   <= 6'h3d;
            sync_q   <= 6'h3d;
            cclk_d_q <= 1'b0;
            mclk_d_q <= 1'b1;
        end else begin
            meta_q   <= {power_down, tx_path_enable, mclk, ci, cclk, cs_n};
            sync_q   <= meta_q;
            cclk_d_q <= sync_q[1];
            mclk_d_q <= sync_q[3];
        end
    end

    assign cs_n_s    = sync_q[0];
    assign ci_s      = sync_q[2];
    assign tx_en_s   = sync_q[4];
    assign pd_s      = sync_q[5];
    assign cclk_rise = sync_q[1] & ~cclk_d_q;
    assign cclk_fall = ~sync_q[1] & cclk_d_q;
    assign mclk_rise = sync_q[3] & ~mclk_d_q;

    // serial control port
    trbg_pkg::trbg_port_state_t state_q;
    logic [2:0] bit_cnt_q;
    logic [7:0] shin_q;
    logic [7:0] cmd_q;
    logic [7:0] shout_q;
    logic [7:0] byte_in;
    logic       wr_stb;

    logic [7:0] clock_q;
    logic [7:0] routing_q;
    logic [7:0] rx_gain_q;
    logic [7:0] tone_ctrl_q;
    logic [7:0] freq_first_q;
    logic [7:0] freq_sec_q;
    logic [7:0] range_q;
    logic [7:0] buzzer_q;

    assign byte_in = {shin_q[6:0], ci_s};

    function automatic logic [7:0] reg_read(input logic [3:0] addr);
        logic [7:0] v;
        v = 8'h00;
        unique case (addr)
            `TRBG_ADDR_CLOCK:      v = clock_q;
            `TRBG_ADDR_ROUTING:    v = routing_q;
            `TRBG_ADDR_RX_GAIN:    v = rx_gain_q;
            `TRBG_ADDR_TONE_CTRL:  v = tone_ctrl_q;
            `TRBG_ADDR_FREQ_FIRST: v = freq_first_q;
            `TRBG_ADDR_FREQ_SEC:   v = freq_sec_q;
            `TRBG_ADDR_RANGE:      v = range_q;
            `TRBG_ADDR_BUZZER:     v = buzzer_q;
            default:               v = 8'h00;
        endcase
        return v;
    endfunction

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state_q   <= trbg_pkg::PORT_IDLE;
            bit_cnt_q <= 3'h0;
            shin_q    <= 8'h00;
            cmd_q     <= 8'h00;
            shout_q   <= 8'h00;
        end else if (cs_n_s) begin
            // chip select high aborts any partial instruction
            state_q   <= trbg_pkg::PORT_IDLE;
            bit_cnt_q <= 3'h0;
        end else begin
            unique case (state_q)
                trbg_pkg::PORT_IDLE: begin
                    state_q   <= trbg_pkg::PORT_CMD;
                    bit_cnt_q <= 3'h0;
                end
                trbg_pkg::PORT_CMD: begin
                    if (cclk_rise) begin
                        shin_q    <= byte_in;
                        bit_cnt_q <= bit_cnt_q + 3'h1;
                        if (bit_cnt_q == 3'h7) begin
                            cmd_q   <= byte_in;
                            shout_q <= reg_read(byte_in[`TRBG_CMD_ADDR_HI:`TRBG_CMD_ADDR_LO]);
                            state_q <= trbg_pkg::PORT_DATA;
                        end
                    end
                end
                trbg_pkg::PORT_DATA: begin
                    if (cclk_rise) begin
                        shin_q    <= byte_in;
                        bit_cnt_q <= bit_cnt_q + 3'h1;
                        if (bit_cnt_q == 3'h7) begin
                            state_q <= trbg_pkg::PORT_DONE;
                        end
                    end
                    if (cclk_fall) begin
                        shout_q <= {shout_q[6:0], 1'b0};
                    end
                end
                trbg_pkg::PORT_DONE: begin
                    state_q <= trbg_pkg::PORT_DONE;
                end
            endcase
        end
    end

    assign wr_stb = !cs_n_s && state_q == trbg_pkg::PORT_DATA && cclk_rise && bit_cnt_q == 3'h7
                    && !cmd_q[`TRBG_CMD_READ_BIT];

    // read data leaves on falling edges so the host samples it on rising ones
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            co_out  <= 1'b0;
            co_oe_n <= 1'b1;
        end else if (cs_n_s) begin
            co_oe_n <= 1'b1;
        end else if (cclk_fall) begin
            if (state_q == trbg_pkg::PORT_DATA && cmd_q[`TRBG_CMD_READ_BIT]) begin
                co_out  <= shout_q[7];
                co_oe_n <= 1'b0;
            end else begin
                co_oe_n <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            clock_q      <= `TRBG_RST_CLOCK;
            routing_q    <= `TRBG_RST_ROUTING;
            rx_gain_q    <= `TRBG_RST_RX_GAIN;
            tone_ctrl_q  <= `TRBG_RST_TONE_CTRL;
            freq_first_q <= `TRBG_RST_FREQ;
            freq_sec_q   <= `TRBG_RST_FREQ;
            range_q      <= `TRBG_RST_RANGE;
            buzzer_q     <= `TRBG_RST_BUZZER;
        end else if (wr_stb) begin
            unique case (cmd_q[`TRBG_CMD_ADDR_HI:`TRBG_CMD_ADDR_LO])
                `TRBG_ADDR_CLOCK:      clock_q      <= byte_in;
                `TRBG_ADDR_ROUTING:    routing_q    <= byte_in;
                `TRBG_ADDR_RX_GAIN:    rx_gain_q    <= byte_in;
                `TRBG_ADDR_TONE_CTRL:  tone_ctrl_q  <= byte_in;
                `TRBG_ADDR_FREQ_FIRST: freq_first_q <= byte_in;
                `TRBG_ADDR_FREQ_SEC:   freq_sec_q   <= byte_in;
                `TRBG_ADDR_RANGE:      range_q      <= byte_in;
                `TRBG_ADDR_BUZZER:     buzzer_q     <= byte_in;
                default:               ;
            endcase
        end
    end

    // 512 kHz tick from master clock; tone pitch then does not depend on mclk rate
    logic [2:0] div_ratio;
    logic [2:0] div_cnt_q;
    logic       tick;

    always_comb begin
        unique case (clock_q[`TRBG_CLK_SEL_HI:`TRBG_CLK_SEL_LO])
            2'b00: div_ratio = `TRBG_DIV_512K;
            2'b01: div_ratio = `TRBG_DIV_1536K;
            2'b10: div_ratio = `TRBG_DIV_2048K;
            2'b11: div_ratio = `TRBG_DIV_2560K;
        endcase
    end

    assign tick = mclk_rise && (div_cnt_q >= div_ratio - 3'h1);

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            div_cnt_q <= 3'h0;
        end else if (tick) begin
            div_cnt_q <= 3'h0;
        end else if (mclk_rise) begin
            div_cnt_q <= div_cnt_q + 3'h1;
        end
    end

    // phase accumulators
    logic [PW-1:0] acc1_q;
    logic [PW-1:0] acc2_q;
    logic [PW-1:0] inc1;
    logic [PW-1:0] inc2;
    logic          en1;
    logic          en2;

    assign en1 = tone_ctrl_q[`TRBG_FIRST_EN_BIT];
    assign en2 = tone_ctrl_q[`TRBG_SECOND_EN_BIT];

    always_comb begin
        unique case (trbg_pkg::trbg_range_t'(range_q[1:0]))
            trbg_pkg::RANGE_HALVED: begin
                inc1 = PW'(freq_first_q);
                inc2 = PW'(freq_sec_q);
            end
            trbg_pkg::RANGE_DOUBLE: begin
                inc1 = PW'({freq_first_q, 2'b00});
                inc2 = PW'({freq_sec_q, 2'b00});
            end
            trbg_pkg::RANGE_STD, trbg_pkg::RANGE_BOTH: begin
                inc1 = PW'({freq_first_q, 1'b0});
                inc2 = PW'({freq_sec_q, 1'b0});
            end
        endcase
    end

    // each source has its own accumulator and frequency register
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            acc1_q <= '0;
            acc2_q <= '0;
        end else if (pd_s) begin
            acc1_q <= '0;
            acc2_q <= '0;
        end else if (tick) begin
            acc1_q <= acc1_q + inc1;
            acc2_q <= acc2_q + inc2;
        end
    end

    logic signed [8:0]  sine1;
    logic signed [8:0]  sine2;
    logic signed [8:0]  wave1;
    logic signed [8:0]  wave2;
    logic signed [17:0] prod2;
    logic signed [9:0]  mix;

    trbg_sine_rom u_sine1 (
        .sys_clk (sys_clk),
        .reset   (reset),
        .phase   (acc1_q[PW-1:PW-6]),
        .sine_q  (sine1)
    );

    trbg_sine_rom u_sine2 (
        .sys_clk (sys_clk),
        .reset   (reset),
        .phase   (acc2_q[PW-1:PW-6]),
        .sine_q  (sine2)
    );

    always_comb begin
        if (tone_ctrl_q[`TRBG_WAVE_BIT]) begin
            wave1 = sine1;
            wave2 = sine2;
        end else begin
            wave1 = acc1_q[PW-1] ? -`TRBG_SQUARE_AMP : `TRBG_SQUARE_AMP;
            wave2 = acc2_q[PW-1] ? -`TRBG_SQUARE_AMP : `TRBG_SQUARE_AMP;
        end
        prod2 = wave2 * `TRBG_SECOND_GAIN;
        mix   = (en1 ? 10'(wave1) : 10'sh000)
              + (en2 ? 10'($signed(prod2[16:8])) : 10'sh000);
    end

    // generator is silent in power down; the host owns on/off cadence
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            tone_sample    <= 10'sh000;
            tx_path_sample <= 10'sh000;
        end else begin
            tone_sample    <= pd_s ? 10'sh000 : mix;
            tx_path_sample <= tone_ctrl_q[`TRBG_TO_TX_BIT] ? tone_sample : tx_amp_sample;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ring_atten_code   <= 4'h0;
            extra_gain_code   <= 4'h0;
            ring_route_select <= 1'b0;
            sidetone_active   <= 1'b0;
        end else begin
            ring_atten_code   <= tone_ctrl_q[`TRBG_ATT_HI:`TRBG_ATT_LO];
            extra_gain_code   <= rx_gain_q[`TRBG_GAIN_HI:`TRBG_GAIN_LO];
            ring_route_select <= routing_q[`TRBG_ROUTE_RING_BIT];
            sidetone_active   <= routing_q[`TRBG_SIDETONE_BIT] & tx_en_s;
        end
    end

    // buzzer: duty/128 of each first-tone period, compared on top 7 phase bits
    logic mark;
    logic gate;
    logic active;

    assign mark   = acc1_q[PW-1:PW-7] < {1'b0, buzzer_q[`TRBG_DUTY_HI:`TRBG_DUTY_LO]};
    assign gate   = !en2 || !acc2_q[PW-1];
    assign active = buzzer_q[`TRBG_BZ_EN_BIT] && en1 && !pd_s && mark && gate;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            buzzer_output <= 1'b0;
        end else begin
            buzzer_output <= buzzer_q[`TRBG_BZ_POL_BIT] ^ active;
        end
    end
endmodule

// File: test/trbg_tone_gen_chk.sv
// port-level assertions for the tone, ring and buzzer generator
module trbg_tone_gen_chk (
    input wire logic              sys_clk,
    input wire logic              reset,
    input wire logic              cs_n,
    input wire logic              cclk,
    input wire logic              ci,
    input wire logic              co_out,
    input wire logic              co_oe_n,
    input wire logic              mclk,
    input wire logic              power_down,
    input wire logic              tx_path_enable,
    input wire logic signed [9:0] tx_amp_sample,
    input wire logic signed [9:0] tx_path_sample,
    input wire logic signed [9:0] tone_sample,
    input wire logic [3:0]        ring_atten_code,
    input wire logic [3:0]        extra_gain_code,
    input wire logic              ring_route_select,
    input wire logic              sidetone_active,
    input wire logic              buzzer_output
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    a_tx_path_mux: assert property (
        tx_path_sample == $past(tx_amp_sample) || tx_path_sample == $past(tone_sample))
        else $error("transmit sample is neither amplifier nor tone");
    // a write cannot land while select has been high this long
    a_pd_buzz_hold: assert property (
        (power_down && cs_n)[*8] |-> $stable(buzzer_output))
        else $error("buzzer moved during power down");
    a_pd_tone_zero: assert property (
        power_down[*8] |-> tone_sample == 10'h000)
        else $error("tone not silent in power down");
    a_sidetone_off: assert property (
        !tx_path_enable[*5] |-> !sidetone_active)
        else $error("sidetone on with transmit path off");
    a_oe_idle: assert property (
        cs_n[*5] |-> co_oe_n)
        else $error("serial out driven while deselected");
    a_oe_release: assert property (
        $rose(cs_n) |-> ##[1:5] co_oe_n)
        else $error("serial out not released after deselect");
    a_co_steady: assert property (
        $changed(co_out) |-> !cclk && !$past(cclk, 2))
        else $error("serial out changed while serial clock high");
    // phase only advances on master clock ticks
    a_tone_needs_mclk: assert property (
        (cs_n && $stable(mclk) && $stable(power_down))[*8] |=> $stable(tone_sample))
        else $error("tone moved without master clock edge");
endmodule

bind trbg_tone_gen trbg_tone_gen_chk chk_u (
    .sys_clk(sys_clk), .reset(reset), .cs_n(cs_n), .cclk(cclk), .ci(ci), .co_out(co_out),
    .co_oe_n(co_oe_n), .mclk(mclk), .power_down(power_down), .tx_path_enable(tx_path_enable),
    .tx_amp_sample(tx_amp_sample), .tx_path_sample(tx_path_sample), .tone_sample(tone_sample),
    .ring_atten_code(ring_atten_code), .extra_gain_code(extra_gain_code),
    .ring_route_select(ring_route_select), .sidetone_active(sidetone_active),
    .buzzer_output(buzzer_output)
);

// File: test/trbg_host_model.sv
// host controller model driving the two-byte serial control port
module trbg_host_model (
    input  wire logic sys_clk,
    output logic      cs_n,
    output logic      cclk,
    output logic      ci,
    input  wire logic co_out,
    input  wire logic co_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        cs_n = 1'b1;
        cclk = 1'b0;
        ci   = 1'b0;
    end

    // serial clock idles low between frames; 4 system cycles per half period
    task automatic xfer(input logic [7:0] cmd, input logic [7:0] wdata, output logic [7:0] rdata);
        logic [15:0] frame;
        frame = {cmd, wdata};
        rdata = 8'h00;
        @(negedge sys_clk);
        cs_n <= 1'b0;
        repeat (4) @(negedge sys_clk);
        for (int i = 15; i >= 0; i--) begin
            ci <= frame[i];
            repeat (4) @(negedge sys_clk);
            cclk <= 1'b1;
            if (i < 8) rdata[i] = (co_oe_n === 1'b0) ? co_out : 1'bx;
            repeat (4) @(negedge sys_clk);
            cclk <= 1'b0;
        end
        repeat (4) @(negedge sys_clk);
        cs_n <= 1'b1;
        // released data line shows no stale value
        ci   <= ~ci;
        repeat (6) @(negedge sys_clk);
    endtask
endmodule

// File: test/trbg_tone_gen_tb.sv
// self-checking bench for the tone, ring and buzzer generator
`include "trbg_regs.svh"

module trbg_tone_gen_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic              sys_clk, reset, cs_n, cclk, ci, co_out, co_oe_n, mclk;
    logic              power_down, tx_path_enable, ring_route_select, sidetone_active, buzzer_output;
    logic signed [9:0] tx_amp_sample, tx_path_sample, tone_sample;
    logic [3:0]        ring_atten_code, extra_gain_code;
    int                bad_count, n_compared, peak;
    logic              saw_mid;
    logic [3:0]        addrs [8] = '{`TRBG_ADDR_CLOCK, `TRBG_ADDR_ROUTING, `TRBG_ADDR_RX_GAIN,
        `TRBG_ADDR_TONE_CTRL, `TRBG_ADDR_FREQ_FIRST, `TRBG_ADDR_FREQ_SEC, `TRBG_ADDR_RANGE, `TRBG_ADDR_BUZZER};
    real               kv [4] = '{0.128, 0.256, 0.064, 0.128};
    real               mclk_half = 976.5625;

    trbg_tone_gen dut_u (.sys_clk(sys_clk), .reset(reset), .cs_n(cs_n), .cclk(cclk), .ci(ci),
        .co_out(co_out), .co_oe_n(co_oe_n), .mclk(mclk), .power_down(power_down),
        .tx_path_enable(tx_path_enable), .tx_amp_sample(tx_amp_sample), .tx_path_sample(tx_path_sample),
        .tone_sample(tone_sample), .ring_atten_code(ring_atten_code), .extra_gain_code(extra_gain_code),
        .ring_route_select(ring_route_select), .sidetone_active(sidetone_active),
        .buzzer_output(buzzer_output));
    trbg_host_model host_u (.sys_clk(sys_clk), .cs_n(cs_n), .cclk(cclk), .ci(ci), .co_out(co_out),
        .co_oe_n(co_oe_n));

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    // master clock starts at 512 kHz to match the default divider
    initial begin
        mclk = 1'b0;
        forever #(mclk_half) mclk = ~mclk;
    end
    always @(negedge sys_clk) begin
        if (int'(tone_sample) > peak) peak = int'(tone_sample);
        if (tone_sample != 10'h000 && tone_sample != 10'h07f && tone_sample != 10'h381) saw_mid = 1'b1;
    end

    task automatic end_sim();
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic fail(input string msg);
        bad_count++;
        $display("MISMATCH at %0t: %s", $time, msg);
    endtask
    task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string what);
        n_compared++;
        if (got !== exp) fail($sformatf("%s got %h expected %h", what, got, exp));
    endtask
    task automatic chk_in(input int got, input int lo, input int hi, input string what);
        n_compared++;
        if (got < lo || got > hi) fail($sformatf("%s got %0d expected %0d..%0d", what, got, lo, hi));
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] r;
        host_u.xfer({a, 4'h0}, d, r);
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        host_u.xfer({a, 4'h0} | (8'h01 << `TRBG_CMD_READ_BIT), 8'h00, d);
    endtask
    // bounded wait while the buzzer pin rests at one level
    task automatic span(input logic lvl, output int n);
        n = 0;
        while (buzzer_output === lvl && n < 60000) begin
            @(negedge sys_clk);
            n++;
        end
        if (n >= 60000) begin
            fail("buzzer stuck");
            end_sim();
        end
    endtask
    // phases restart from zero when power down is lifted; idle span optional to keep runs short
    task automatic run_tone(input logic pol, input bit full, output int act, output int idle);
        int skip;
        peak = 0;
        saw_mid = 1'b0;
        idle = 0;
        power_down = 1'b0;
        span(pol, skip);
        span(~pol, act);
        act += skip;
        if (full) span(pol, idle);
        power_down = 1'b1;
    endtask
    function automatic int exp_cyc(real k, int n, int duty);
        return int'(50.0e6 * k / n * duty / 128.0);
    endfunction
    task automatic near(input int got, input int e, input string what);
        chk_in(got, e - e / 50 - 110, e + e / 50 + 110, what);
    endtask

    initial begin
        logic [7:0] r;
        int act, idle;
        reset = 1'b1;
        power_down = 1'b1;
        tx_path_enable = 1'b1;
        tx_amp_sample = 10'h155;
        bad_count = 0;
        n_compared = 0;
        repeat (8) @(negedge sys_clk);
        reset = 1'b0;
        repeat (6) @(negedge sys_clk);
        chk({9'h0, co_oe_n}, 10'h001, "serial out idle");
        foreach (addrs[i]) begin
            rd(addrs[i], r);
            chk({2'b00, r}, 10'h000, "reset value");
        end
        for (int i = 1; i < 8; i++) begin
            wr(addrs[i], 8'h3c ^ {addrs[i], addrs[i]});
            rd(addrs[i], r);
            chk({2'b00, r}, {2'b00, 8'h3c ^ {addrs[i], addrs[i]}}, "readback");
        end
        wr(4'hf, 8'h5a);
        rd(4'hf, r);
        chk({2'b00, r}, 10'h000, "unmapped read");
        wr(`TRBG_ADDR_TONE_CTRL, 8'ha0);
        chk({6'h0, ring_atten_code}, 10'h00a, "attenuator code");
        wr(`TRBG_ADDR_RX_GAIN, 8'h0c);
        chk({6'h0, extra_gain_code}, 10'h00c, "extra gain code");
        wr(`TRBG_ADDR_ROUTING, 8'h24);
        chk({8'h0, ring_route_select, sidetone_active}, 10'h003, "route and sidetone");
        tx_path_enable = 1'b0;
        repeat (6) @(negedge sys_clk);
        chk({9'h0, sidetone_active}, 10'h000, "sidetone gated");
        tx_path_enable = 1'b1;
        wr(`TRBG_ADDR_ROUTING, 8'h00);
        chk({9'h0, ring_route_select}, 10'h000, "route cleared");
        repeat (2) @(negedge sys_clk);
        chk(tx_path_sample, 10'h155, "amplifier on transmit path");
        wr(`TRBG_ADDR_FREQ_FIRST, 8'hff);
        wr(`TRBG_ADDR_BUZZER, 8'h88);
        wr(`TRBG_ADDR_TONE_CTRL, 8'h08);
        for (int g = 0; g < 4; g++) begin
            wr(`TRBG_ADDR_RANGE, g[7:0]);
            run_tone(1'b0, 1'b0, act, idle);
            near(act, exp_cyc(kv[g], 255, 8), "range timing");
            chk({9'h0, saw_mid}, 10'h000, "square levels");
            chk_in(peak, 127, 127, "first amplitude");
        end
        wr(`TRBG_ADDR_TONE_CTRL, 8'h0a);
        wr(`TRBG_ADDR_RANGE, 8'h02);
        for (int p = 0; p < 2; p++) begin
            wr(`TRBG_ADDR_BUZZER, {1'b1, p[0], 6'h20});
            run_tone(p[0], 1'b1, act, idle);
            near(act, exp_cyc(0.064, 255, 32), "duty width");
            near(idle, exp_cyc(0.064, 255, 96), "idle width");
            chk({9'h0, saw_mid}, 10'h001, "sine levels");
        end
        // faster master clock with matching divider must keep the same pitch
        wr(`TRBG_ADDR_CLOCK, 8'hc0);
        mclk_half = 195.3125;
        wr(`TRBG_ADDR_FREQ_FIRST, 8'h80);
        wr(`TRBG_ADDR_FREQ_SEC, 8'hff);
        wr(`TRBG_ADDR_BUZZER, 8'hbf);
        wr(`TRBG_ADDR_TONE_CTRL, 8'h0c);
        run_tone(1'b0, 1'b0, act, idle);
        near(act, exp_cyc(0.064, 255, 64), "second tone gating");
        chk_in(peak, 225, 229, "summed amplitude");
        wr(`TRBG_ADDR_TONE_CTRL, 8'h04);
        peak = 0;
        power_down = 1'b0;
        repeat (300) @(negedge sys_clk);
        chk_in(peak, 99, 101, "second amplitude");
        wr(`TRBG_ADDR_TONE_CTRL, 8'h09);
        repeat (300) @(negedge sys_clk);
        chk_in(int'(tx_path_sample) * int'(tx_path_sample), 16129, 16129, "tone on transmit path");
        wr(`TRBG_ADDR_BUZZER, 8'h40);
        chk({9'h0, buzzer_output}, 10'h001, "disabled idle high");
        wr(`TRBG_ADDR_BUZZER, 8'hc8);
        power_down = 1'b1;
        repeat (10) @(negedge sys_clk);
        chk({9'h0, buzzer_output}, 10'h001, "power down idle high");
        wr(`TRBG_ADDR_BUZZER, 8'h08);
        chk({9'h0, buzzer_output}, 10'h000, "disabled idle low");
        end_sim();
    end
endmodule
